// >>> mms_host.sv
// AXI4-Lite host model that drives the sequencer's register bus.
// Assumes registered slave outputs; tasks are called from the bench top.
`timescale 1ns/100ps
module mms_host
(
  input wire logic mclk_in,
  input wire mms_pkg::mms_axi_rsp_t axi_rsp_in,
  output mms_pkg::mms_axi_req_t axi_req_out
);
  initial axi_req_out = '0;

  // Released payload shows the inverse so stale values never look valid
  task automatic write(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
    logic done;
    begin
      done = 1'b0;
      resp = 2'h3;
      @(posedge mclk_in);
      axi_req_out.awvalid <= 1'b1;
      axi_req_out.awaddr <= addr;
      axi_req_out.wvalid <= 1'b1;
      axi_req_out.wdata <= data;
      axi_req_out.wstrb <= 4'hF;
      axi_req_out.bready <= 1'b1;
      while (!done)
      begin
        @(posedge mclk_in);
        if (axi_req_out.awvalid && axi_rsp_in.awready)
        begin
          axi_req_out.awvalid <= 1'b0;
          axi_req_out.awaddr <= ~addr;
        end
        if (axi_req_out.wvalid && axi_rsp_in.wready)
        begin
          axi_req_out.wvalid <= 1'b0;
          axi_req_out.wdata <= ~data;
          axi_req_out.wstrb <= 4'h0;
        end
        if (axi_req_out.bready && axi_rsp_in.bvalid)
        begin
          resp = axi_rsp_in.bresp;
          axi_req_out.bready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask

  task automatic read(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
    logic done;
    begin
      done = 1'b0;
      data = 32'h0;
      resp = 2'h3;
      @(posedge mclk_in);
      axi_req_out.arvalid <= 1'b1;
      axi_req_out.araddr <= addr;
      axi_req_out.rready <= 1'b1;
      while (!done)
      begin
        @(posedge mclk_in);
        if (axi_req_out.arvalid && axi_rsp_in.arready)
        begin
          axi_req_out.arvalid <= 1'b0;
          axi_req_out.araddr <= ~addr;
        end
        if (axi_req_out.rready && axi_rsp_in.rvalid)
        begin
          data = axi_rsp_in.rdata;
          resp = axi_rsp_in.rresp;
          axi_req_out.rready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
endmodule

// >>> mms_phase_timer.sv
// Down-counter that times one sequencer phase.
// Assumes count_in is at least one whenever start_in is high.
`timescale 1ns/100ps
module mms_phase_timer
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [mms_pkg::CNT_W-1:0] count_in,
  output logic done_out
);

  mms_pkg::mms_tmr_state_t st;
  mms_pkg::mms_tmr_state_t next_st;

  always_comb
  begin
    next_st = st;
    // Restart wins so back-to-back phases lose no cycle
    if (start_in)
    begin
      next_st.cnt = count_in;
    end
    else if (st.cnt != '0)
    begin
      next_st.cnt = st.cnt - mms_pkg::ONE_CYCLE;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign done_out = (st.cnt == mms_pkg::ONE_CYCLE);

endmodule

// >>> mms_pkg.sv
// Constants, types and register map of the measurement mode sequencer.
// Assumes one 100 MHz clock and an AXI4-Lite master with 32-bit data.
//
// Summary of operation
// - Once reset is released the block sits in sleep with no host action needed.
// - The two-bit mode field selects sleep with 00 and forced mode with 01.
// - In sleep no conversion runs and the heater stays off.
// - Writing forced mode starts exactly one full_measurement_cycle.
// - At the end of that cycle the mode field drops back to sleep by itself.
// - Conversions run strictly in the order temperature, pressure, humidity, gas.
// - The hot-plate heater is driven only during the gas part of a forced cycle.
// - Ten heater profiles, numbered 0 to 9, each hold a setpoint and a heating time.
// - A mode write that lands during a running cycle is held back until that cycle ends.
// - While such a change is held back, further mode and control writes are dropped.
// - Oversampling runs from sixteen-fold down to zero, and zero skips that conversion.
// - The gas phase uses the heater profile named by the four-bit heater_profile_select field.
// - Heating and gas conversion run only when the gas-run enable bit is 1.
package mms_pkg;

  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int NUM_PROF = 10;

  localparam logic [ADDR_W-1:0] OFF_CTRL_MEAS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL_HUM = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL_GAS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PROF_BASE = 8'h40;

  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_FORCED = 2'h1;

  localparam logic [2:0] OSR_SKIP = 3'h0;

  localparam logic [CNT_W-1:0] SAMPLE_CYCLES = 16'h0008;
  localparam logic [CNT_W-1:0] HEAT_UNIT_CYCLES = 16'h0004;
  localparam logic [CNT_W-1:0] GAS_CONV_CYCLES = 16'h0010;
  localparam logic [CNT_W-1:0] ONE_CYCLE = 16'h0001;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_LAUNCH = 3'b001,
    PH_TEMP = 3'b010,
    PH_PRES = 3'b011,
    PH_HUM = 3'b100,
    PH_HEAT = 3'b101,
    PH_GAS = 3'b110
  } mms_phase_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } mms_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mms_axi_rsp_t;

  typedef struct packed {
    mms_axi_rsp_t rsp;
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] mode;
    logic [2:0] osrs_t;
    logic [2:0] osrs_p;
    logic [2:0] osrs_h;
    logic [3:0] heater_profile_select;
    logic run_gas;
    logic [NUM_PROF-1:0][15:0] prof;
    logic pending;
    logic [7:0] pend_val;
    mms_phase_t ph;
    logic busy;
    logic heat_on;
    logic [7:0] setpoint;
  } mms_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } mms_tmr_state_t;

endpackage

// >>> mms_sequencer.sv
// Mode control and measurement sequencer with its AXI4-Lite register slave.
// Assumes a single clock; the analog front end follows phase_out and heater outputs.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module mms_sequencer
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire mms_pkg::mms_axi_req_t axi_req_in,
  output mms_pkg::mms_axi_rsp_t axi_rsp_out,
  output mms_pkg::mms_phase_t phase_out,
  output logic busy_out,
  output logic heater_on_out,
  output logic [7:0] heater_setpoint_out
);

  mms_pkg::mms_state_t st;
  mms_pkg::mms_state_t next_st;
  logic tmr_start;
  logic [mms_pkg::CNT_W-1:0] tmr_count;
  logic tmr_done;
  logic wr_fire;
  logic meas_defer;
  logic launch_now;
  logic end_now;
  logic [32:0] wr_cur;
  logic [32:0] rd_cur;
  logic [31:0] mask;
  logic [31:0] merged;
  logic [7:0] cmd;
  logic [15:0] prof_word;
  mms_pkg::mms_phase_t nxt;

  function automatic logic [32:0] reg_read(input mms_pkg::mms_state_t s, input logic [mms_pkg::ADDR_W-1:0] a);
    logic [mms_pkg::ADDR_W-1:0] off;
    logic [32:0] r;
    off = a - mms_pkg::OFF_PROF_BASE;
    r = '0;
    if (a[7:2] == mms_pkg::OFF_CTRL_MEAS[7:2])
      r = {1'b1, 24'h000000, s.osrs_p, s.osrs_t, s.mode};
    else if (a[7:2] == mms_pkg::OFF_CTRL_HUM[7:2])
      r = {1'b1, 29'h00000000, s.osrs_h};
    else if (a[7:2] == mms_pkg::OFF_CTRL_GAS[7:2])
      r = {1'b1, 27'h0000000, s.run_gas, s.heater_profile_select};
    else if (a[7:2] == mms_pkg::OFF_STATUS[7:2])
      r = {1'b1, 27'h0000000, s.ph, s.pending, s.busy};
    else if (a >= mms_pkg::OFF_PROF_BASE && off[7:2] < 6'(mms_pkg::NUM_PROF))
      r = {1'b1, 16'h0000, s.prof[off[5:2]]};
    return r;
  endfunction

  // Zero skips the conversion; codes five and above all mean sixteen samples
  function automatic logic [mms_pkg::CNT_W-1:0] osr_cycles(input logic [2:0] code);
    logic [mms_pkg::CNT_W-1:0] n;
    case (code)
      3'h0: n = 16'h0000;
      3'h1: n = 16'h0001;
      3'h2: n = 16'h0002;
      3'h3: n = 16'h0004;
      3'h4: n = 16'h0008;
      default: n = 16'h0010;
    endcase
    return mms_pkg::CNT_W'(n * mms_pkg::SAMPLE_CYCLES);
  endfunction

  function automatic mms_pkg::mms_phase_t next_phase(input mms_pkg::mms_phase_t cur, input mms_pkg::mms_state_t s);
    mms_pkg::mms_phase_t r;
    r = mms_pkg::PH_IDLE;
    if (cur < mms_pkg::PH_TEMP && s.osrs_t != mms_pkg::OSR_SKIP)
      r = mms_pkg::PH_TEMP;
    else if (cur < mms_pkg::PH_PRES && s.osrs_p != mms_pkg::OSR_SKIP)
      r = mms_pkg::PH_PRES;
    else if (cur < mms_pkg::PH_HUM && s.osrs_h != mms_pkg::OSR_SKIP)
      r = mms_pkg::PH_HUM;
    else if (cur < mms_pkg::PH_HEAT && s.run_gas)
      r = mms_pkg::PH_HEAT;
    else if (cur == mms_pkg::PH_HEAT)
      r = mms_pkg::PH_GAS;
    return r;
  endfunction

  // Out-of-range select falls back to profile 0
  assign prof_word = st.prof[(st.heater_profile_select < 4'(mms_pkg::NUM_PROF)) ? st.heater_profile_select : 4'h0];

  mms_phase_timer u_timer
  (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .start_in(tmr_start),
    .count_in(tmr_count),
    .done_out(tmr_done)
  );

  always_comb
  begin
    next_st = st;
    launch_now = 1'b0;
    end_now = 1'b0;
    tmr_start = 1'b0;
    tmr_count = mms_pkg::ONE_CYCLE;
    cmd = st.pend_val;
    nxt = mms_pkg::PH_IDLE;
    wr_cur = reg_read(st, st.awaddr);
    rd_cur = reg_read(st, axi_req_in.araddr);
    mask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
    merged = (wr_cur[31:0] & ~mask) | (st.wdata & mask);
    wr_fire = st.aw_got && st.w_got && !st.rsp.bvalid;
    meas_defer = wr_fire && wr_cur[32] && !st.pending && st.busy && st.awaddr[7:2] == mms_pkg::OFF_CTRL_MEAS[7:2];

    if (axi_req_in.awvalid && st.rsp.awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = axi_req_in.awaddr;
    end
    if (axi_req_in.wvalid && st.rsp.wready)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = axi_req_in.wdata;
      next_st.wstrb = axi_req_in.wstrb;
    end
    if (st.rsp.bvalid && axi_req_in.bready)
      next_st.rsp.bvalid = 1'b0;

    if (wr_fire)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp = wr_cur[32] ? mms_pkg::RESP_OKAY : mms_pkg::RESP_SLVERR;
      // Dropped writes still answer OKAY, as the device ignores them silently
      if (wr_cur[32] && !st.pending)
      begin
        if (st.awaddr[7:2] == mms_pkg::OFF_CTRL_MEAS[7:2])
        begin
          if (st.busy)
          begin
            next_st.pending = 1'b1;
            next_st.pend_val = merged[7:0];
          end
          else
          begin
            next_st.mode = merged[1:0];
            next_st.osrs_t = merged[4:2];
            next_st.osrs_p = merged[7:5];
            launch_now = (merged[1:0] == mms_pkg::MODE_FORCED);
          end
        end
        else if (st.awaddr[7:2] == mms_pkg::OFF_CTRL_HUM[7:2])
          next_st.osrs_h = merged[2:0];
        else if (st.awaddr[7:2] == mms_pkg::OFF_CTRL_GAS[7:2])
        begin
          next_st.heater_profile_select = merged[3:0];
          next_st.run_gas = merged[4];
        end
        else if (st.awaddr >= mms_pkg::OFF_PROF_BASE)
          next_st.prof[4'(st.awaddr[7:2] - mms_pkg::OFF_PROF_BASE[7:2])] = merged[15:0];
      end
    end

    case (st.ph)
      mms_pkg::PH_IDLE:
      begin
        if (launch_now)
          next_st.ph = mms_pkg::PH_LAUNCH;
      end
      default:
      begin
        if (st.ph == mms_pkg::PH_LAUNCH || tmr_done)
        begin
          nxt = next_phase(st.ph, st);
          if (nxt == mms_pkg::PH_IDLE)
            end_now = 1'b1;
          else
          begin
            next_st.ph = nxt;
            tmr_start = 1'b1;
            case (nxt)
              mms_pkg::PH_TEMP: tmr_count = osr_cycles(st.osrs_t);
              mms_pkg::PH_PRES: tmr_count = osr_cycles(st.osrs_p);
              mms_pkg::PH_HUM: tmr_count = osr_cycles(st.osrs_h);
              mms_pkg::PH_HEAT: tmr_count = (prof_word[15:8] == 8'h00) ? mms_pkg::ONE_CYCLE :
                mms_pkg::CNT_W'({8'h00, prof_word[15:8]} * mms_pkg::HEAT_UNIT_CYCLES);
              mms_pkg::PH_GAS: tmr_count = mms_pkg::GAS_CONV_CYCLES;
              default: tmr_count = mms_pkg::ONE_CYCLE;
            endcase
          end
        end
      end
    endcase

    if (end_now)
    begin
      next_st.ph = mms_pkg::PH_IDLE;
      next_st.mode = mms_pkg::MODE_SLEEP;
      // A mode write landing in the last cycle takes effect now, not lost
      if (st.pending || meas_defer)
      begin
        if (!st.pending)
          cmd = merged[7:0];
        next_st.mode = cmd[1:0];
        next_st.osrs_t = cmd[4:2];
        next_st.osrs_p = cmd[7:5];
        next_st.pending = 1'b0;
        if (cmd[1:0] == mms_pkg::MODE_FORCED)
          next_st.ph = mms_pkg::PH_LAUNCH;
      end
    end

    next_st.busy = (next_st.ph != mms_pkg::PH_IDLE);
    next_st.heat_on = (next_st.ph == mms_pkg::PH_HEAT || next_st.ph == mms_pkg::PH_GAS);
    if (next_st.ph == mms_pkg::PH_HEAT && st.ph != mms_pkg::PH_HEAT)
      next_st.setpoint = prof_word[7:0];
    else if (!next_st.heat_on)
      next_st.setpoint = 8'h00;

    if (st.rsp.rvalid && axi_req_in.rready)
      next_st.rsp.rvalid = 1'b0;
    if (axi_req_in.arvalid && st.rsp.arready)
    begin
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata = rd_cur[31:0];
      next_st.rsp.rresp = rd_cur[32] ? mms_pkg::RESP_OKAY : mms_pkg::RESP_SLVERR;
    end
    next_st.rsp.arready = !next_st.rsp.rvalid;
    next_st.rsp.awready = !next_st.aw_got && !next_st.rsp.bvalid;
    next_st.rsp.wready = !next_st.w_got && !next_st.rsp.bvalid;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign axi_rsp_out = st.rsp;
  assign phase_out = st.ph;
  assign busy_out = st.busy;
  assign heater_on_out = st.heat_on;
  assign heater_setpoint_out = st.setpoint;

  a_sleep_after_reset: assert property (@(posedge mclk_in) rst_in |=>
    (st.ph == mms_pkg::PH_IDLE && st.mode == mms_pkg::MODE_SLEEP && !busy_out))
    else $error("not in sleep after reset");

  a_sleep_quiet: assert property (@(posedge mclk_in) disable iff (rst_in)
    st.mode == mms_pkg::MODE_SLEEP && !st.pending |-> !heater_on_out && phase_out == mms_pkg::PH_IDLE && !busy_out)
    else $error("activity while in sleep");

  a_forced_launch: assert property (@(posedge mclk_in) disable iff (rst_in)
    launch_now |=> st.ph == mms_pkg::PH_LAUNCH && st.mode == mms_pkg::MODE_FORCED ##1 st.ph != mms_pkg::PH_LAUNCH)
    else $error("forced write did not start one cycle");

  a_return_sleep: assert property (@(posedge mclk_in) disable iff (rst_in)
    end_now && !st.pending && !meas_defer |=> st.mode == mms_pkg::MODE_SLEEP && !busy_out)
    else $error("no return to sleep after cycle");

  a_phase_order: assert property (@(posedge mclk_in) disable iff (rst_in)
    $changed(st.ph) && st.ph > mms_pkg::PH_LAUNCH |-> $past(st.ph) < st.ph)
    else $error("conversion order broken");

  a_heater_gas_only: assert property (@(posedge mclk_in) disable iff (rst_in)
    heater_on_out |-> (st.ph == mms_pkg::PH_HEAT || st.ph == mms_pkg::PH_GAS) && st.mode == mms_pkg::MODE_FORCED)
    else $error("heater on outside gas phase");

  a_defer_mode: assert property (@(posedge mclk_in) disable iff (rst_in)
    meas_defer && !end_now |=> st.pending && st.mode == $past(st.mode) && busy_out)
    else $error("mode write during cycle not deferred");

  a_discard_pending: assert property (@(posedge mclk_in) disable iff (rst_in)
    st.pending && wr_fire && !end_now |=> $stable(st.pend_val) && $stable(st.prof) && $stable(st.run_gas))
    else $error("write accepted while change pending");

  a_skip_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st.ph == mms_pkg::PH_TEMP |-> st.osrs_t != mms_pkg::OSR_SKIP) and
    (st.ph == mms_pkg::PH_PRES |-> st.osrs_p != mms_pkg::OSR_SKIP) and
    (st.ph == mms_pkg::PH_HUM && $past(st.ph) != mms_pkg::PH_HUM |-> $past(st.osrs_h) != mms_pkg::OSR_SKIP))
    else $error("skipped conversion was run");

  a_profile_used: assert property (@(posedge mclk_in) disable iff (rst_in)
    st.ph == mms_pkg::PH_HEAT && $past(st.ph) != mms_pkg::PH_HEAT |-> heater_setpoint_out == $past(prof_word[7:0]))
    else $error("wrong heater profile");

  a_gas_enable: assert property (@(posedge mclk_in) disable iff (rst_in)
    st.ph == mms_pkg::PH_HEAT && $past(st.ph) != mms_pkg::PH_HEAT |-> $past(st.run_gas))
    else $error("gas phase without enable");

  a_busy_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(busy_out) |-> $past(end_now) && !st.pending && st.mode != mms_pkg::MODE_FORCED)
    else $error("busy dropped outside cycle end");

  c_full_cycle: cover property (@(posedge mclk_in) disable iff (rst_in)
    st.ph == mms_pkg::PH_GAS ##1 st.ph == mms_pkg::PH_IDLE);
  c_deferred: cover property (@(posedge mclk_in) disable iff (rst_in)
    st.pending ##1 !st.pending && st.ph == mms_pkg::PH_LAUNCH);
  c_dropped_write: cover property (@(posedge mclk_in) disable iff (rst_in) st.pending && wr_fire);
  c_reserved_mode: cover property (@(posedge mclk_in) disable iff (rst_in) !busy_out && st.mode[1]);
  c_mid_reset: cover property (@(posedge mclk_in) busy_out ##1 rst_in);

endmodule

// >>> testbench.sv
// Self-checking bench for the measurement mode sequencer.
// Assumes the host model drives the bus; a monitor logs phases per clock.
`timescale 1ns/100ps
module testbench;
  logic mclk_in;
  logic rst_in;
  mms_pkg::mms_axi_req_t axi_req;
  mms_pkg::mms_axi_rsp_t axi_rsp;
  mms_pkg::mms_phase_t phase;
  logic busy;
  logic heater_on;
  logic [7:0] setpoint;
  int err_count;
  int tests_run;
  int run_len;
  int launches;
  int mon_bad;
  int i;
  logic [7:0] sp_seen;
  mms_pkg::mms_phase_t ph_log[$];
  int dur_log[$];

  mms_sequencer mms_sequencer_i(.mclk_in(mclk_in), .rst_in(rst_in), .axi_req_in(axi_req), .axi_rsp_out(axi_rsp),
    .phase_out(phase), .busy_out(busy), .heater_on_out(heater_on), .heater_setpoint_out(setpoint));
  mms_host mms_host_i(.mclk_in(mclk_in), .axi_rsp_in(axi_rsp), .axi_req_out(axi_req));

  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // Logs each phase change and its length; heater and busy must track phase
  always @(posedge mclk_in)
  begin
    if (rst_in === 1'b0)
    begin
      if (heater_on !== (phase === mms_pkg::PH_HEAT || phase === mms_pkg::PH_GAS))
        mon_bad++;
      if (busy !== (phase !== mms_pkg::PH_IDLE))
        mon_bad++;
      if (heater_on === 1'b1)
        sp_seen = setpoint;
      else if (setpoint !== 8'h00)
        mon_bad++;
      if (ph_log.size() == 0 || phase !== ph_log[$])
      begin
        if (ph_log.size() != 0)
          dur_log.push_back(run_len);
        ph_log.push_back(phase);
        run_len = 1;
        if (phase === mms_pkg::PH_LAUNCH)
          launches++;
      end
      else
        run_len++;
    end
  end

  task automatic test_done();
    begin
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      tests_run++;
      if (got !== exp)
      begin
        err_count++;
        $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task automatic check_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
    begin
      tests_run++;
      if (got !== exp)
      begin
        err_count++;
        $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    begin
      mms_host_i.write(a, d, r);
      check_resp("write response", er, r);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    begin
      mms_host_i.read(a, d, r);
      check_resp("read response", er, r);
      check_word("read data", ed, d);
    end
  endtask

  // Delay keeps the clear away from the monitor's clock edge
  task automatic clear_log();
    begin
      #1;
      ph_log.delete();
      dur_log.delete();
      launches = 0;
      sp_seen = 8'h00;
    end
  endtask

  task automatic wait_idle();
    int n;
    begin
      n = 0;
      repeat (2) @(posedge mclk_in);
      while (busy !== 1'b0 && n < 3000)
      begin
        @(posedge mclk_in);
        n++;
      end
      repeat (2) @(posedge mclk_in);
    end
  endtask

  // Phases after the leading idle, ending in idle; lengths of all but the last
  task automatic check_run(input int n, input int ep[8], input int ed[8]);
    int k;
    begin
      check_word("phase count", n + 1, ph_log.size());
      for (k = 0; k < n && k + 1 < ph_log.size(); k++)
      begin
        check_word("phase", ep[k], {29'h0, ph_log[k + 1]});
        if (k < n - 1 && k + 1 < dur_log.size())
          check_word("phase length", ed[k], dur_log[k + 1]);
      end
    end
  endtask

  task automatic end_test(input string name);
    begin
      check_word("monitor faults", 0, mon_bad);
      $display("test %s done", name);
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    err_count++;
    $display("unexpected watchdog: expected finish seen hang");
    test_done();
  end

  initial
  begin
    rst_in = 1'b1;
    err_count = 0;
    tests_run = 0;
    mon_bad = 0;
    launches = 0;
    run_len = 0;
    sp_seen = 8'h00;
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    clear_log();
    repeat (20) @(posedge mclk_in);
    check_word("launches", 0, launches);
    check_word("phase", 0, {29'h0, phase});
    rdchk(mms_pkg::OFF_STATUS, 32'h0, mms_pkg::RESP_OKAY);
    rdchk(mms_pkg::OFF_CTRL_MEAS, 32'h0, mms_pkg::RESP_OKAY);
    rdchk(8'h30, 32'h0, mms_pkg::RESP_SLVERR);
    wr(8'h30, 32'h1, mms_pkg::RESP_SLVERR);
    end_test("reset");

    for (i = 0; i < mms_pkg::NUM_PROF; i++)
      wr(mms_pkg::OFF_PROF_BASE + 8'(4 * i), {16'h0, 8'(i + 1), 8'(8'h10 + i)}, mms_pkg::RESP_OKAY);
    for (i = 0; i < mms_pkg::NUM_PROF; i++)
      rdchk(mms_pkg::OFF_PROF_BASE + 8'(4 * i), {16'h0, 8'(i + 1), 8'(8'h10 + i)}, mms_pkg::RESP_OKAY);
    wr(8'h68, 32'h0000_FFFF, mms_pkg::RESP_SLVERR);
    rdchk(8'h68, 32'h0, mms_pkg::RESP_SLVERR);
    end_test("profiles");

    wr(mms_pkg::OFF_CTRL_HUM, 32'h1, mms_pkg::RESP_OKAY);
    wr(mms_pkg::OFF_CTRL_GAS, 32'h13, mms_pkg::RESP_OKAY);
    clear_log();
    wr(mms_pkg::OFF_CTRL_MEAS, 32'h29, mms_pkg::RESP_OKAY);
    wait_idle();
    check_run(7, '{1, 2, 3, 4, 5, 6, 0, 0}, '{1, 16, 8, 8, 16, 16, 0, 0});
    check_word("launches", 1, launches);
    check_word("setpoint", 32'h13, {24'h0, sp_seen});
    rdchk(mms_pkg::OFF_CTRL_MEAS, 32'h28, mms_pkg::RESP_OKAY);
    end_test("full cycle");

    wr(mms_pkg::OFF_CTRL_HUM, 32'h0, mms_pkg::RESP_OKAY);
    wr(mms_pkg::OFF_CTRL_GAS, 32'h03, mms_pkg::RESP_OKAY);
    clear_log();
    wr(mms_pkg::OFF_CTRL_MEAS, 32'h21, mms_pkg::RESP_OKAY);
    wait_idle();
    check_run(3, '{1, 3, 0, 0, 0, 0, 0, 0}, '{1, 8, 0, 0, 0, 0, 0, 0});
    check_word("setpoint", 32'h0, {24'h0, sp_seen});
    clear_log();
    wr(mms_pkg::OFF_CTRL_MEAS, 32'h0, mms_pkg::RESP_OKAY);
    wr(mms_pkg::OFF_CTRL_MEAS, 32'h3, mms_pkg::RESP_OKAY);
    repeat (10) @(posedge mclk_in);
    check_word("launches", 0, launches);
    rdchk(mms_pkg::OFF_CTRL_MEAS, 32'h03, mms_pkg::RESP_OKAY);
    end_test("skips");

    clear_log();
    wr(mms_pkg::OFF_CTRL_MEAS, 32'h15, mms_pkg::RESP_OKAY);
    wr(mms_pkg::OFF_CTRL_MEAS, 32'h05, mms_pkg::RESP_OKAY);
    wr(mms_pkg::OFF_CTRL_HUM, 32'h5, mms_pkg::RESP_OKAY);
    wr(mms_pkg::OFF_CTRL_MEAS, 32'hE1, mms_pkg::RESP_OKAY);
    wr(mms_pkg::OFF_PROF_BASE, 32'h0000_FFFF, mms_pkg::RESP_OKAY);
    rdchk(mms_pkg::OFF_STATUS, 32'h0B, mms_pkg::RESP_OKAY);
    wait_idle();
    check_run(5, '{1, 2, 1, 2, 0, 0, 0, 0}, '{1, 128, 1, 8, 0, 0, 0, 0});
    check_word("launches", 2, launches);
    rdchk(mms_pkg::OFF_CTRL_MEAS, 32'h04, mms_pkg::RESP_OKAY);
    rdchk(mms_pkg::OFF_CTRL_HUM, 32'h0, mms_pkg::RESP_OKAY);
    rdchk(mms_pkg::OFF_PROF_BASE, 32'h0110, mms_pkg::RESP_OKAY);
    rdchk(mms_pkg::OFF_STATUS, 32'h0, mms_pkg::RESP_OKAY);
    end_test("deferred");

    wr(mms_pkg::OFF_CTRL_MEAS, 32'h15, mms_pkg::RESP_OKAY);
    repeat (10) @(posedge mclk_in);
    check_word("busy", 1, {31'h0, busy});
    rst_in <= 1'b1;
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    check_word("phase", 0, {29'h0, phase});
    check_word("heater", 0, {31'h0, heater_on});
    rdchk(mms_pkg::OFF_STATUS, 32'h0, mms_pkg::RESP_OKAY);
    rdchk(mms_pkg::OFF_CTRL_MEAS, 32'h0, mms_pkg::RESP_OKAY);
    end_test("reset in cycle");
    test_done();
  end
endmodule
